// File: logic/fxal_addr_shift.sv
// byte-wise address shift register with a received-byte count
module fxal_addr_shift #(
    parameter int WIDTH = 32,
    parameter int CNT_W = 3
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clear,
    input wire logic shift,
    input wire logic [7:0] byte_in,
    output logic [WIDTH-1:0] value,
    output logic [CNT_W-1:0] count
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [WIDTH-1:0] value_reg; // collected address, msb first
    logic [WIDTH-1:0] value_next;
    logic [CNT_W-1:0] count_reg; // bytes taken since clear
    logic [CNT_W-1:0] count_next;

    // next value: clear wins, else shift a byte in at the bottom
    always_comb begin
        value_next = value_reg;
        count_next = count_reg;
        if (clear) begin
            value_next = '0;
            count_next = '0;
        end else if (shift) begin
            value_next = {value_reg[WIDTH-9:0], byte_in};
            count_next = count_reg + CNT_W'(1);
        end
    end

    // registers only
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            value_reg <= '0;
            count_reg <= '0;
        end else begin
            value_reg <= value_next;
            count_reg <= count_next;
        end
    end

    assign value = value_reg;
    assign count = count_reg;
endmodule : fxal_addr_shift

// File: logic/fxal_top.sv
// extended address forming for a serial flash command decoder
// ------------------------------------------------------------
// ------------------------------------------------------------

package fxal_pkg;
    // ------------------------------------------------------------
    // command classes as given by the opcode decoder
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        FXAL_CMD_LEGACY = 3'h0, // legacy array command
        FXAL_CMD_NEW4B = 3'h1,  // newer array command, 4-byte address
        FXAL_CMD_BANKWR = 3'h2, // load bank register from next byte
        FXAL_CMD_IDREAD = 3'h3, // identification_read_command
        FXAL_CMD_OTHER = 3'h4   // other address space, e.g. otp
    } fxal_cmd_t;

    // address space tags on the output
    typedef enum logic [1:0] {
        FXAL_SP_ARRAY = 2'h0,
        FXAL_SP_ID = 2'h1,
        FXAL_SP_OTHER = 2'h2
    } fxal_space_t;

    // sequencer states
    typedef enum logic [1:0] {
        FXAL_ST_IDLE = 2'h0,
        FXAL_ST_ADDR = 2'h1,
        FXAL_ST_BANK = 2'h2
    } fxal_state_t;

    // ------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------
    localparam int FXAL_BANK_EXT_BIT = 7;         // extended mode bit
    localparam logic [7:0] FXAL_BANK_RST = 8'h00; // bank reset value
    localparam logic [2:0] FXAL_LEN_SHORT = 3'h3; // legacy byte count
    localparam logic [2:0] FXAL_LEN_LONG = 3'h4;  // extended byte count
    localparam int FXAL_LOW_ADDR_W = 24;          // bits kept in low part
endpackage : fxal_pkg

module fxal_top
    import fxal_pkg::*;
#(
    parameter bit LOW_DENSITY = 1'b0 // 1: array uses only 24 bits
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic cmd_start,
    input wire logic [2:0] cmd_kind,
    input wire logic cmd_is_write,
    input wire logic cmd_end,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    output logic addr_valid,
    output logic [31:0] addr_out,
    output logic [1:0] addr_space,
    output logic write_allow,
    output logic id_write_reject,
    output logic [7:0] bank_out,
    output logic ext_mode,
    output logic addr_len4
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    fxal_state_t state_reg; // sequencer state
    fxal_state_t state_next;
    fxal_cmd_t kind_reg; // class of the command in flight
    fxal_cmd_t kind_next;
    logic wr_reg; // command in flight writes
    logic wr_next;
    logic [7:0] bank_reg; // bank register with mode bit
    logic [7:0] bank_next;
    logic [2:0] need_reg; // address bytes this command takes
    logic [2:0] need_next;
    logic valid_reg; // one-cycle address strobe
    logic valid_next;
    logic [31:0] addr_reg; // formed effective address
    logic [31:0] addr_next;
    logic [1:0] space_reg; // space tag of addr_reg
    logic [1:0] space_next;
    logic wallow_reg; // write permitted at this address
    logic wallow_next;
    logic reject_reg; // pulse: write to id space refused
    logic reject_next;
    logic len4_reg; // current command takes four bytes
    logic len4_next;
    logic sh_clear; // restart address collection
    logic sh_shift; // take one address byte
    logic [31:0] sh_value; // collected address bytes
    logic [2:0] sh_count; // address bytes collected
    logic [31:0] full_addr; // address as the command formed it
    logic ext_on; // extended mode currently set
    logic take_long; // command class needs four bytes

    // ------------------------------------------------------------
    // address byte collector
    // ------------------------------------------------------------
    fxal_addr_shift #(
        .WIDTH(32),
        .CNT_W(3)
    ) u_shift (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .clear(sh_clear),
        .shift(sh_shift),
        .byte_in(byte_data),
        .value(sh_value),
        .count(sh_count)
    );

    // ------------------------------------------------------------
    // address forming
    // ------------------------------------------------------------
    assign ext_on = bank_reg[FXAL_BANK_EXT_BIT];

    // length decision for the arriving command class
    always_comb begin
        case (fxal_cmd_t'(cmd_kind))
            FXAL_CMD_LEGACY: take_long = ext_on;
            FXAL_CMD_NEW4B: take_long = 1'b1;
            FXAL_CMD_OTHER: take_long = 1'b1;
            default: take_long = 1'b0;
        endcase
    end

    // short address: bank bits above, 24 received bits below
    always_comb begin
        if (need_reg == FXAL_LEN_SHORT) begin
            full_addr = {1'b0, bank_reg[6:0],
                sh_value[FXAL_LOW_ADDR_W-1:0]};
        end else begin
            full_addr = sh_value;
        end
    end

    // ------------------------------------------------------------
    // sequencer: next values
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        kind_next = kind_reg;
        wr_next = wr_reg;
        bank_next = bank_reg;
        need_next = need_reg;
        valid_next = 1'b0;
        addr_next = addr_reg;
        space_next = space_reg;
        wallow_next = wallow_reg;
        reject_next = 1'b0;
        len4_next = len4_reg;
        sh_clear = 1'b0;
        sh_shift = 1'b0;
        if (cmd_start) begin
            // a new command restarts whatever was in flight
            sh_clear = 1'b1;
            kind_next = fxal_cmd_t'(cmd_kind);
            wr_next = cmd_is_write;
            need_next = take_long ? FXAL_LEN_LONG : FXAL_LEN_SHORT;
            len4_next = take_long;
            case (fxal_cmd_t'(cmd_kind))
                FXAL_CMD_BANKWR: begin
                    state_next = FXAL_ST_BANK;
                end
                FXAL_CMD_IDREAD: begin
                    // id space opens at zero, never writable
                    state_next = FXAL_ST_IDLE;
                    valid_next = 1'b1;
                    addr_next = '0;
                    space_next = FXAL_SP_ID;
                    wallow_next = 1'b0;
                    reject_next = cmd_is_write;
                end
                FXAL_CMD_LEGACY, FXAL_CMD_NEW4B, FXAL_CMD_OTHER: begin
                    state_next = FXAL_ST_ADDR;
                end
                default: begin
                    state_next = FXAL_ST_IDLE;
                end
            endcase
        end else if (cmd_end) begin
            state_next = FXAL_ST_IDLE;
        end else begin
            case (state_reg)
                FXAL_ST_IDLE: begin
                    state_next = FXAL_ST_IDLE;
                end
                FXAL_ST_ADDR: begin
                    sh_shift = byte_valid;
                    if (sh_count == need_reg) begin
                        // all address bytes in: publish the address
                        state_next = FXAL_ST_IDLE;
                        valid_next = 1'b1;
                        wallow_next = wr_reg;
                        if (kind_reg == FXAL_CMD_OTHER) begin
                            space_next = FXAL_SP_OTHER;
                            addr_next = full_addr;
                        end else begin
                            space_next = FXAL_SP_ARRAY;
                            addr_next = full_addr;
                            if (LOW_DENSITY) begin
                                addr_next[31:FXAL_LOW_ADDR_W] =
                                    8'h00;
                            end
                        end
                    end
                end
                FXAL_ST_BANK: begin
                    if (byte_valid) begin
                        bank_next = byte_data;
                        state_next = FXAL_ST_IDLE;
                    end
                end
                default: begin
                    state_next = FXAL_ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // sequencer: registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= FXAL_ST_IDLE;
            kind_reg <= FXAL_CMD_LEGACY;
            wr_reg <= 1'b0;
            bank_reg <= FXAL_BANK_RST;
            need_reg <= FXAL_LEN_SHORT;
            valid_reg <= 1'b0;
            addr_reg <= '0;
            space_reg <= FXAL_SP_ARRAY;
            wallow_reg <= 1'b0;
            reject_reg <= 1'b0;
            len4_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            kind_reg <= kind_next;
            wr_reg <= wr_next;
            bank_reg <= bank_next;
            need_reg <= need_next;
            valid_reg <= valid_next;
            addr_reg <= addr_next;
            space_reg <= space_next;
            wallow_reg <= wallow_next;
            reject_reg <= reject_next;
            len4_reg <= len4_next;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from flip-flops
    // ------------------------------------------------------------
    assign addr_valid = valid_reg;
    assign addr_out = addr_reg;
    assign addr_space = space_reg;
    assign write_allow = wallow_reg;
    assign id_write_reject = reject_reg;
    assign bank_out = bank_reg;
    assign ext_mode = bank_reg[FXAL_BANK_EXT_BIT];
    assign addr_len4 = len4_reg;
endmodule : fxal_top

// File: verification/fxal_chk.sv
// assertion checker for the extended address forming block
module fxal_chk
    import fxal_pkg::*;
#(
    parameter bit LOW_DENSITY = 1'b0
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic cmd_start,
    input wire logic [2:0] cmd_kind,
    input wire logic cmd_is_write,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    input wire logic cmd_end,
    input wire logic addr_valid,
    input wire logic [31:0] addr_out,
    input wire logic [1:0] addr_space,
    input wire logic write_allow,
    input wire logic id_write_reject,
    input wire logic [7:0] bank_out,
    input wire logic ext_mode,
    input wire logic addr_len4
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    AST_RST_CLEAR: assert property (
        $fell(sys_rst) |-> bank_out == 8'h00 && !ext_mode && !addr_len4)
        else $error("bank or length not cleared by reset");
    AST_LEN_LEGACY: assert property (
        cmd_start && cmd_kind == FXAL_CMD_LEGACY
        |=> addr_len4 == $past(ext_mode) && ext_mode == bank_out[7])
        else $error("legacy length does not follow mode bit");
    AST_LEN_NEW: assert property (
        cmd_start && cmd_kind inside {FXAL_CMD_NEW4B, FXAL_CMD_OTHER}
        |=> addr_len4)
        else $error("new or other command not four bytes");
    AST_BANK_LOAD: assert property (
        cmd_start && cmd_kind == FXAL_CMD_BANKWR
        ##1 !byte_valid && !cmd_start && !cmd_end
        ##1 byte_valid && !cmd_start && !cmd_end
        |=> bank_out == $past(byte_data))
        else $error("bank not loaded from byte");
    AST_SHORT_ADDR: assert property (
        addr_valid && !addr_len4 && !$past(cmd_start)
        && addr_space == FXAL_SP_ARRAY |-> addr_out[31:24] ==
        (LOW_DENSITY ? 8'h00 : {1'b0, bank_out[6:0]}))
        else $error("short address high bits wrong");
    AST_LOW_DENS: assert property (
        addr_valid && addr_space == FXAL_SP_ARRAY
        |-> !LOW_DENSITY || addr_out[31:24] == 8'h00)
        else $error("low density high bits not dropped");
    AST_ID_ANSWER: assert property (
        cmd_start && cmd_kind == FXAL_CMD_IDREAD
        |=> addr_valid && addr_space == FXAL_SP_ID && addr_out == 32'h0)
        else $error("id read answer wrong");
    AST_ID_REFUSE: assert property (
        cmd_start && cmd_kind == FXAL_CMD_IDREAD && cmd_is_write
        |=> id_write_reject && !write_allow)
        else $error("id write not refused");
    // main scenarios reached
    cover property (id_write_reject);
    cover property (addr_valid && addr_len4);
    cover property (addr_valid && ext_mode);
endmodule : fxal_chk

// File: verification/fxal_host.sv
// host controller model: command classes and address bytes
module fxal_host (
    input wire logic clk_sys,
    output logic cmd_start,
    output logic [2:0] cmd_kind,
    output logic cmd_is_write,
    output logic cmd_end,
    output logic byte_valid,
    output logic [7:0] byte_data
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle levels at time zero
    initial begin
        cmd_start = 1'b0;
        cmd_kind = 3'h7;
        cmd_is_write = 1'b0;
        cmd_end = 1'b0;
        byte_valid = 1'b0;
        byte_data = 8'h00;
    end
    // one-cycle command pulse, class lines scrambled after it
    task automatic cmd(input logic [2:0] k, input logic w);
        @(negedge clk_sys);
        cmd_start = 1'b1;
        cmd_kind = k;
        cmd_is_write = w;
        @(negedge clk_sys);
        cmd_start = 1'b0;
        cmd_kind = ~k;
        cmd_is_write = ~w;
    endtask : cmd
    // one-cycle chip-select end pulse, aborts any collection
    task automatic end_cmd();
        @(negedge clk_sys);
        cmd_end = 1'b1;
        @(negedge clk_sys);
        cmd_end = 1'b0;
    endtask : end_cmd
    // one byte; the data line shows the inverse once released
    task automatic put(input logic [7:0] b);
        @(negedge clk_sys);
        byte_valid = 1'b1;
        byte_data = b;
        @(negedge clk_sys);
        byte_valid = 1'b0;
        byte_data = ~b;
    endtask : put
    // n address bytes, most significant first, all of them sent
    task automatic addr(input logic [31:0] a, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            put(a[8*i+:8]);
        end
    endtask : addr
endmodule : fxal_host

// File: verification/flash_extended_address_logic_bench.sv
// self-checking bench for the extended address forming block
module flash_extended_address_logic_bench
    import fxal_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys;
    logic sys_rst;
    logic cmd_start, cmd_is_write, cmd_end, byte_valid;
    logic [2:0] cmd_kind;
    logic [7:0] byte_data;
    // index 0: full density, index 1: low density
    logic av[2], wa[2], rj[2], em[2], l4[2];
    logic [31:0] ao[2];
    logic [1:0] as[2];
    logic [7:0] bk[2];
    int fails = 0;
    int num_checks = 0;
    int cycles = 0;
    fxal_host u_fxal_host (.clk_sys(clk_sys), .cmd_start(cmd_start),
        .cmd_kind(cmd_kind), .cmd_is_write(cmd_is_write),
        .cmd_end(cmd_end), .byte_valid(byte_valid), .byte_data(byte_data));
    for (genvar g = 0; g < 2; g++) begin : g_dut
        fxal_top #(.LOW_DENSITY(g == 1)) u_fxal_top (.clk_sys(clk_sys),
            .sys_rst(sys_rst), .cmd_start(cmd_start), .cmd_kind(cmd_kind),
            .cmd_is_write(cmd_is_write), .cmd_end(cmd_end),
            .byte_valid(byte_valid), .byte_data(byte_data),
            .addr_valid(av[g]), .addr_out(ao[g]), .addr_space(as[g]),
            .write_allow(wa[g]), .id_write_reject(rj[g]),
            .bank_out(bk[g]), .ext_mode(em[g]), .addr_len4(l4[g]));
    end
    // 200 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            end_sim();
        end
    end
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic end_sim();
        if (fails == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim
    // wait for the address strobe, then judge both densities
    task automatic expect_addr(logic [31:0] e0, e1, logic [1:0] sp);
        int n;
        n = 0;
        while (av[0] !== 1'b1 && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
        chk("valid", {av[1], av[0]}, 2'h3);
        chk("addr_full", ao[0], e0);
        chk("addr_low", ao[1], e1);
        chk("space", as[0], sp);
        chk("space_low", as[1], sp);
    endtask : expect_addr
    // bank load, then a legacy write with a short address
    task automatic t_short(logic [7:0] b, logic [23:0] a);
        u_fxal_host.cmd(FXAL_CMD_BANKWR, 1'b0);
        u_fxal_host.put(b);
        chk("bank", bk[0], b);
        u_fxal_host.cmd(FXAL_CMD_LEGACY, 1'b1);
        chk("len4", l4[0], 1'b0);
        u_fxal_host.addr(a, 3);
        expect_addr({1'b0, b[6:0], a}, a, FXAL_SP_ARRAY);
        chk("write", wa[0], 1'b1);
    endtask : t_short
    // mode bit set: legacy takes four bytes
    task automatic t_ext();
        u_fxal_host.cmd(FXAL_CMD_BANKWR, 1'b0);
        u_fxal_host.put(8'h83);
        chk("ext", em[0], 1'b1);
        u_fxal_host.cmd(FXAL_CMD_LEGACY, 1'b0);
        chk("len4", l4[0], 1'b1);
        u_fxal_host.addr(32'ha1b2c3d4, 4);
        expect_addr(32'ha1b2c3d4, 32'h00b2c3d4, FXAL_SP_ARRAY);
    endtask : t_ext
    // new and other-space commands with the mode bit clear
    task automatic t_long(logic [2:0] k, logic [1:0] sp, logic [31:0] e1);
        u_fxal_host.cmd(FXAL_CMD_BANKWR, 1'b0);
        u_fxal_host.put(8'h00);
        u_fxal_host.cmd(k, 1'b0);
        chk("len4", l4[0], 1'b1);
        u_fxal_host.addr(32'hffffffff, 4);
        expect_addr(32'hffffffff, e1, sp);
    endtask : t_long
    // id read, plain and with the write class
    task automatic t_id(logic w);
        u_fxal_host.cmd(FXAL_CMD_IDREAD, w);
        chk("reject", rj[0], w);
        expect_addr(32'h0, 32'h0, FXAL_SP_ID);
        chk("write", wa[0], 1'b0);
    endtask : t_id
    // reset in mid-run drops the bank back to zero
    task automatic t_rst_mid();
        u_fxal_host.cmd(FXAL_CMD_BANKWR, 1'b0);
        u_fxal_host.put(8'hff);
        @(negedge clk_sys);
        sys_rst = 1'b1;
        @(negedge clk_sys);
        sys_rst = 1'b0;
        chk("bank", bk[0], 8'h00);
        u_fxal_host.cmd(FXAL_CMD_LEGACY, 1'b0);
        u_fxal_host.addr(32'h00abcdef, 3);
        expect_addr(32'h00abcdef, 32'h00abcdef, FXAL_SP_ARRAY);
    endtask : t_rst_mid
    // chip select ends mid-address, an unused class, then stray bytes;
    // the address of the previous scenario must still stand
    task automatic t_abort();
        u_fxal_host.cmd(FXAL_CMD_LEGACY, 1'b1);
        u_fxal_host.addr(32'h00001122, 2);
        u_fxal_host.end_cmd();
        u_fxal_host.put(8'h33);
        u_fxal_host.cmd(3'h5, 1'b0);
        u_fxal_host.addr(32'h44556677, 4);
        repeat (2) @(negedge clk_sys);
        chk("abort_valid", av[0], 1'b0);
        chk("abort_addr", ao[0], 32'h00abcdef);
        u_fxal_host.cmd(FXAL_CMD_LEGACY, 1'b0);
        u_fxal_host.addr(32'h00010203, 3);
        expect_addr(32'h00010203, 32'h00010203, FXAL_SP_ARRAY);
        u_fxal_host.put(8'h99);
        repeat (2) @(negedge clk_sys);
        chk("extra_byte", ao[0], 32'h00010203);
    endtask : t_abort
    // main sequence
    initial begin
        sys_rst = 1'b1;
        repeat (5) @(negedge clk_sys);
        sys_rst = 1'b0;
        chk("bank", {l4[0], em[0], bk[0]}, 10'h000);
        t_short(8'h05, 24'h123456);
        t_short(8'h7f, 24'hffffff);
        t_short(8'h00, 24'hffffff);
        t_ext();
        t_long(FXAL_CMD_NEW4B, FXAL_SP_ARRAY, 32'h00ffffff);
        t_long(FXAL_CMD_OTHER, FXAL_SP_OTHER, 32'hffffffff);
        t_id(1'b0);
        t_id(1'b1);
        t_rst_mid();
        t_abort();
        end_sim();
    end
endmodule : flash_extended_address_logic_bench

bind fxal_top fxal_chk #(.LOW_DENSITY(LOW_DENSITY)) u_fxal_chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .cmd_start(cmd_start),
    .cmd_kind(cmd_kind), .cmd_is_write(cmd_is_write),
    .byte_valid(byte_valid), .byte_data(byte_data), .cmd_end(cmd_end),
    .addr_valid(addr_valid), .addr_out(addr_out),
    .addr_space(addr_space), .write_allow(write_allow),
    .id_write_reject(id_write_reject), .bank_out(bank_out),
    .ext_mode(ext_mode), .addr_len4(addr_len4));
